/* src/tmps_cfg.svh */
// Register map, field positions, reset values and timing counts of the timer block
`ifndef TMPS_CFG_SVH
`define TMPS_CFG_SVH
`define TMPS_ADDR_TIMER 8'h01
`define TMPS_ADDR_IRQ 8'h0B
`define TMPS_ADDR_IRQ_HI 8'h8B
`define TMPS_ADDR_OPTION 8'h81
`define TMPS_ADDR_PORTA 8'h85
`define TMPS_RST_TIMER 8'h00
`define TMPS_RST_IRQ 8'h00
`define TMPS_RST_OPTION 8'hFF
`define TMPS_RST_PORTA 8'h3F
`define TMPS_PORTA_MASK 8'h3F
`define TMPS_BIT_FLAG 2
`define TMPS_BIT_IRQ_EN 5
`define TMPS_TIMER_MAX 8'hFF
`define TMPS_OSC_NS 8
`define TMPS_PHASES_PER_INSTR 4
`define TMPS_INHIBIT_INSTR 2'h2
`endif

/* src/tmps_pkg.sv */
// Types used by the timer module only; prescaler and synchroniser modules do not import them
package tmps_pkg;
   // Gray sequence through the four oscillator phases of one instruction cycle
   typedef enum logic [1:0]
   {
      TMPS_Q1 = 2'h0,
      TMPS_Q2 = 2'h1,
      TMPS_Q3 = 2'h3,
      TMPS_Q4 = 2'h2
   } tmps_phase_t;

   typedef struct packed {
      logic [1:0] spare;
      logic count_source_sel;
      logic count_edge_sel;
      logic scaler_assign;
      logic [2:0] scale_ratio;
   } tmps_option_t;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } tmps_bus_req_t;
endpackage

/* src/tmps_sync.sv */
// Two-flop synchroniser for a level arriving from outside the clock domain
`timescale 1ns/1ps
module tmps_sync (
   input wire logic core_clk_in,
   input wire logic rst_in,
   input wire logic async_in,
   output logic sync_out
);
   logic meta_ff;
   logic sync_ff;

   always_ff @(posedge core_clk_in)
   begin
      if (rst_in)
      begin
         meta_ff <= 1'b0;
         sync_ff <= 1'b0;
      end
      else
      begin
         meta_ff <= async_in;
         sync_ff <= meta_ff;
      end
   end

   assign sync_out = sync_ff;
endmodule

/* src/tmps_scaler.sv */
// Shared 8-bit prescaler: ripple count of step pulses, one tap picked by the ratio
`timescale 1ns/1ps
module tmps_scaler (
   input wire logic core_clk_in,
   input wire logic rst_in,
   input wire logic clear_in,
   input wire logic step_in,
   input wire logic [2:0] ratio_in,
   output logic scaled_out
);
   logic [7:0] count_ff;
   logic scaled_ff;

   // Clear has priority over a step landing in the same cycle
   always_ff @(posedge core_clk_in)
   begin
      if (rst_in || clear_in)
         count_ff <= 8'h00;
      else if (step_in)
         count_ff <= count_ff + 8'h01;
   end

   // Tap n toggles every 2^n steps: a square wave dividing by 2^(n+1)
   always_ff @(posedge core_clk_in)
   begin
      if (rst_in || clear_in)
         scaled_ff <= 1'b0;
      else
         scaled_ff <= count_ff[ratio_in];
   end

   assign scaled_out = scaled_ff;
endmodule

/* src/tmps_top.sv */
// Timer/counter with shared prescaler, pin synchroniser and register port
// ==========================================================
// Operation
// - Unscaled pin feeds sampler on Q2, Q4
// - Prescaler divides pin before sync, symmetrical
// - Pin or prescaled source counts only after synchronised edge
// - One prescaler: timer or watchdog, never both
// - Assign bit and ratio pick owner, division
// - Timer write clears prescaler when timer-owned
// - Watchdog clear clears prescaler when watchdog-owned
// - Prescaler count has no software address
// - Owner may change while running
// - Source is instruction clock or pin
// - Rollover sets overflow flag, bit 2
// - Option bits: source, edge, assign, ratio
// - Timer ratios 1:2 to 1:256
// - Write blocks counting two instruction cycles
// - Edge bit clear rising, set falling
// - Overflow on FF to 00 roll
`timescale 1ns/1ps
`include "tmps_cfg.svh"
module tmps_top (
   input wire logic core_clk_in,
   input wire logic rst_in,
   input wire logic [7:0] reg_addr_in,
   input wire logic [7:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   output logic [7:0] reg_rdata_out,
   input wire logic ext_count_input_in,
   input wire logic watchdog_tick_in,
   input wire logic watchdog_clear_op_in,
   output logic watchdog_tick_out,
   output logic overflow_flag_out,
   output logic [7:0] timer_count_out,
   output logic [7:0] porta_direction_out
);
   // ==========================================================
   // Register port decode
   tmps_pkg::tmps_bus_req_t req;
   logic wr_timer;
   logic wr_irq;
   logic wr_option;
   logic wr_porta;
   logic sel_irq;

   assign req.addr = reg_addr_in;
   assign req.wdata = reg_wdata_in;
   assign req.wr = reg_wr_in;
   assign req.rd = reg_rd_in;

   // The interrupt control register answers in both banks
   assign sel_irq = (req.addr == `TMPS_ADDR_IRQ) || (req.addr == `TMPS_ADDR_IRQ_HI);
   assign wr_timer = req.wr && (req.addr == `TMPS_ADDR_TIMER);
   assign wr_irq = req.wr && sel_irq;
   assign wr_option = req.wr && (req.addr == `TMPS_ADDR_OPTION);
   assign wr_porta = req.wr && (req.addr == `TMPS_ADDR_PORTA);

   // ==========================================================
   // Software registers
   logic [7:0] option_ff;
   logic [7:0] irq_ff;
   logic [7:0] porta_ff;
   tmps_pkg::tmps_option_t opt;
   logic timer_owned;

   // Owner and ratio may change at any write, no stop or reset needed
   always_ff @(posedge core_clk_in)
   begin
      if (rst_in)
         option_ff <= `TMPS_RST_OPTION;
      else if (wr_option)
         option_ff <= req.wdata;
   end

   assign opt = tmps_pkg::tmps_option_t'(option_ff);
   assign timer_owned = !opt.scaler_assign;

   always_ff @(posedge core_clk_in)
   begin
      if (rst_in)
         porta_ff <= `TMPS_RST_PORTA;
      else if (wr_porta)
         porta_ff <= req.wdata & `TMPS_PORTA_MASK;
   end

   // ==========================================================
   // Instruction phases
   tmps_pkg::tmps_phase_t phase_ff;
   logic at_q2;
   logic at_q4;
   logic instr_end;

   // Core clock stands for the oscillator; four phases make one instruction
   always_ff @(posedge core_clk_in)
   begin
      if (rst_in)
         phase_ff <= tmps_pkg::TMPS_Q1;
      else
      begin
         unique case (phase_ff)
            tmps_pkg::TMPS_Q1: phase_ff <= tmps_pkg::TMPS_Q2;
            tmps_pkg::TMPS_Q2: phase_ff <= tmps_pkg::TMPS_Q3;
            tmps_pkg::TMPS_Q3: phase_ff <= tmps_pkg::TMPS_Q4;
            tmps_pkg::TMPS_Q4: phase_ff <= tmps_pkg::TMPS_Q1;
         endcase
      end
   end

   assign at_q2 = (phase_ff == tmps_pkg::TMPS_Q2);
   assign at_q4 = (phase_ff == tmps_pkg::TMPS_Q4);
   assign instr_end = at_q4;

   // ==========================================================
   // Count pin and edge selection
   logic pin_sync;
   logic pin_lvl;
   logic pin_prev_ff;
   logic pin_rise;

   tmps_sync u_pin_sync (
      .core_clk_in(core_clk_in),
      .rst_in(rst_in),
      .async_in(ext_count_input_in),
      .sync_out(pin_sync)
   );

   // Inverting the pin turns falling edges into rising ones
   assign pin_lvl = pin_sync ^ opt.count_edge_sel;

   always_ff @(posedge core_clk_in)
   begin
      if (rst_in)
         // Reset option picks the falling edge, so an idle-low pin reads high
         pin_prev_ff <= 1'b1;
      else
         pin_prev_ff <= pin_lvl;
   end

   assign pin_rise = pin_lvl && !pin_prev_ff;

   // ==========================================================
   // Shared prescaler
   logic src_event;
   logic scaler_step;
   logic scaler_clear;
   logic scaled;
   logic scaled_prev_ff;
   logic scaled_rise;

   // Selected timer source as an event stream
   assign src_event = opt.count_source_sel ? pin_rise : instr_end;

   // Steps come from whichever side owns the counter
   assign scaler_step = timer_owned ? src_event : watchdog_tick_in;

   assign scaler_clear = (wr_timer && timer_owned)
                       || (watchdog_clear_op_in && !timer_owned);

   // Count has no address; only its tap leaves this instance
   tmps_scaler u_scaler (
      .core_clk_in(core_clk_in),
      .rst_in(rst_in),
      .clear_in(scaler_clear),
      .step_in(scaler_step),
      .ratio_in(opt.scale_ratio),
      .scaled_out(scaled)
   );

   always_ff @(posedge core_clk_in)
   begin
      if (rst_in)
         scaled_prev_ff <= 1'b0;
      else
         scaled_prev_ff <= scaled;
   end

   assign scaled_rise = scaled && !scaled_prev_ff;

   // ==========================================================
   // Watchdog side of the prescaler
   logic wd_tick_ff;

   // Undivided ticks pass through while the timer owns the counter
   always_ff @(posedge core_clk_in)
   begin
      if (rst_in)
         wd_tick_ff <= 1'b0;
      else if (timer_owned)
         wd_tick_ff <= watchdog_tick_in;
      else
         wd_tick_ff <= scaled_rise;
   end

   // ==========================================================
   // Phase sampler
   logic sample_lvl;
   logic sample_ff;
   logic sync_rise_ff;

   // Without the prescaler the edge-selected pin itself is sampled
   assign sample_lvl = timer_owned ? scaled : pin_lvl;

   // Sampled on Q2 and Q4 only, so narrow pulses may be missed
   always_ff @(posedge core_clk_in)
   begin
      if (rst_in)
      begin
         sample_ff <= 1'b1;
         sync_rise_ff <= 1'b0;
      end
      else if (at_q2 || at_q4)
      begin
         sample_ff <= sample_lvl;
         sync_rise_ff <= sample_lvl && !sample_ff;
      end
      else
         sync_rise_ff <= 1'b0;
   end

   // ==========================================================
   // Increment request
   logic inc_req;

   // Internal source without prescaler counts every instruction cycle
   always_comb
   begin
      if (!opt.count_source_sel && !timer_owned)
         inc_req = instr_end;
      else
         inc_req = sync_rise_ff;
   end

   // ==========================================================
   // Write inhibit window
   logic [1:0] inhibit_ff;
   logic inc_ok;

   always_ff @(posedge core_clk_in)
   begin
      if (rst_in)
         inhibit_ff <= 2'h0;
      else if (wr_timer)
         inhibit_ff <= `TMPS_INHIBIT_INSTR;
      else if (instr_end && (inhibit_ff != 2'h0))
         inhibit_ff <= inhibit_ff - 2'h1;
   end

   // Increments landing in the window are dropped, not deferred
   assign inc_ok = inc_req && (inhibit_ff == 2'h0);

   // ==========================================================
   // Timer count
   logic [7:0] timer_ff;
   logic rollover;

   always_ff @(posedge core_clk_in)
   begin
      if (rst_in)
         timer_ff <= `TMPS_RST_TIMER;
      else if (wr_timer)
         timer_ff <= req.wdata;
      else if (inc_ok)
         timer_ff <= timer_ff + 8'h01;
   end

   assign rollover = inc_ok && (timer_ff == `TMPS_TIMER_MAX);

   // ==========================================================
   // Interrupt control register
   logic flag_ff;

   // Other bits are plain storage for the interrupt logic outside
   always_ff @(posedge core_clk_in)
   begin
      if (rst_in)
         irq_ff <= `TMPS_RST_IRQ;
      else if (wr_irq)
         irq_ff <= req.wdata;
   end

   // A rollover in the same cycle as a software clear wins
   always_ff @(posedge core_clk_in)
   begin
      if (rst_in)
         flag_ff <= 1'b0;
      else if (rollover)
         flag_ff <= 1'b1;
      else if (wr_irq)
         flag_ff <= req.wdata[`TMPS_BIT_FLAG];
   end

   // ==========================================================
   // Read port
   logic [7:0] irq_view;
   logic [7:0] nxt_rdata;
   logic [7:0] rdata_ff;

   always_comb
   begin
      irq_view = irq_ff;
      irq_view[`TMPS_BIT_FLAG] = flag_ff;
   end

   // Unmapped addresses, the prescaler among them, read as zero
   always_comb
   begin
      nxt_rdata = 8'h00;
      if (req.rd)
      begin
         if (req.addr == `TMPS_ADDR_TIMER)
            nxt_rdata = timer_ff;
         else if (sel_irq)
            nxt_rdata = irq_view;
         else if (req.addr == `TMPS_ADDR_OPTION)
            nxt_rdata = option_ff;
         else if (req.addr == `TMPS_ADDR_PORTA)
            nxt_rdata = porta_ff;
      end
   end

   // Data stand only in the cycle after the strobe
   always_ff @(posedge core_clk_in)
   begin
      if (rst_in)
         rdata_ff <= 8'h00;
      else
         rdata_ff <= nxt_rdata;
   end

   // ==========================================================
   // Outputs
   logic ovf_out_ff;
   logic [7:0] timer_out_ff;

   always_ff @(posedge core_clk_in)
   begin
      if (rst_in)
      begin
         ovf_out_ff <= 1'b0;
         timer_out_ff <= `TMPS_RST_TIMER;
      end
      else
      begin
         ovf_out_ff <= flag_ff;
         timer_out_ff <= timer_ff;
      end
   end

   assign reg_rdata_out = rdata_ff;
   assign watchdog_tick_out = wd_tick_ff;
   assign overflow_flag_out = ovf_out_ff;
   assign timer_count_out = timer_out_ff;
   assign porta_direction_out = porta_ff;
endmodule

/* testbench/tmps_checker.sv */
// Port-level assertions for the timer block
`timescale 1ns/1ps
`include "tmps_cfg.svh"
module tmps_checker (
   input wire logic core_clk_in,
   input wire logic rst_in,
   input wire logic [7:0] reg_addr_in,
   input wire logic [7:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   input wire logic [7:0] reg_rdata_out,
   input wire logic ext_count_input_in,
   input wire logic watchdog_tick_in,
   input wire logic watchdog_clear_op_in,
   input wire logic watchdog_tick_out,
   input wire logic overflow_flag_out,
   input wire logic [7:0] timer_count_out,
   input wire logic [7:0] porta_direction_out
);
   logic [7:0] opt_ff;
   default clocking cb @(posedge core_clk_in);
   endclocking
   default disable iff (rst_in);
   // ==========================================================
   // Option shadow: ownership is not visible at the ports
   always_ff @(posedge core_clk_in)
   begin
      if (rst_in)
         opt_ff <= `TMPS_RST_OPTION;
      else if (reg_wr_in && reg_addr_in == `TMPS_ADDR_OPTION)
         opt_ff <= reg_wdata_in;
   end
   property p_rd_idle;
      !reg_rd_in |=> reg_rdata_out == 8'h00;
   endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("stray read data");
   property p_unmapped;
      reg_rd_in && reg_addr_in == 8'h02 |=> reg_rdata_out == 8'h00;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read");
   property p_wr_load;
      reg_wr_in && reg_addr_in == `TMPS_ADDR_TIMER |=> ##1
         (timer_count_out == $past(reg_wdata_in, 2)) ##1 $stable(timer_count_out) [*3];
   endproperty
   a_wr_load: assert property (p_wr_load) else $error("timer write");
   property p_step;
      timer_count_out != $past(timer_count_out) && !$past(reg_wr_in, 2)
         |-> timer_count_out == $past(timer_count_out) + 8'h01;
   endproperty
   a_step: assert property (p_step) else $error("timer jump");
   property p_ovf_set;
      $past(timer_count_out) == 8'hFF && timer_count_out == 8'h00 && !$past(reg_wr_in, 2)
         |-> overflow_flag_out;
   endproperty
   a_ovf_set: assert property (p_ovf_set) else $error("no overflow");
   property p_ovf_cause;
      $rose(overflow_flag_out) |-> timer_count_out == 8'h00 || $past(reg_wr_in, 2);
   endproperty
   a_ovf_cause: assert property (p_ovf_cause) else $error("stray overflow");
   property p_wd_direct;
      !opt_ff[3] && watchdog_tick_in |=> watchdog_tick_out;
   endproperty
   a_wd_direct: assert property (p_wd_direct) else $error("tick lost");
   property p_wd_div;
      opt_ff[3] && $past(opt_ff[3], 4) && watchdog_tick_out |=> !watchdog_tick_out;
   endproperty
   a_wd_div: assert property (p_wd_div) else $error("tick undivided");
   c_ovf: cover property ($rose(overflow_flag_out));
   c_wd: cover property (opt_ff[3] && watchdog_tick_out);
   c_wr: cover property (reg_wr_in && reg_addr_in == `TMPS_ADDR_TIMER);
endmodule

/* testbench/tmps_pulse_src.sv */
// External count source on the count pin
`timescale 1ns/1ps
module tmps_pulse_src (
   input wire logic core_clk_in,
   output logic count_pin_out
);
   initial count_pin_out = 1'b0;
   // Three periods per level: over the two-period floor, and a six-period cycle
   task automatic toggle(input int n);
      for (int i = 0; i < n; i++)
      begin
         @(posedge core_clk_in);
         count_pin_out <= ~count_pin_out;
         repeat (2) @(posedge core_clk_in);
      end
   endtask
endmodule

/* testbench/tmps_top_test.sv */
// Self-checking bench for the timer block
`timescale 1ns/1ps
module tmps_top_test;
   logic core_clk_in = 1'b0;
   logic rst_in = 1'b1;
   logic [7:0] reg_addr_in = 8'h00;
   logic [7:0] reg_wdata_in = 8'h00;
   logic reg_wr_in = 1'b0;
   logic reg_rd_in = 1'b0;
   logic tick = 1'b0;
   logic clr = 1'b0;
   logic pin;
   logic wd_out;
   logic ovf;
   logic [7:0] rdata;
   logic [7:0] tcount;
   logic [7:0] porta;
   int failures = 0;
   int check_count = 0;
   int wd_outs = 0;
   int n0;
   always #4 core_clk_in = ~core_clk_in;
   always @(posedge core_clk_in)
      if (wd_out === 1'b1)
         wd_outs++;
   tmps_top u_dut (
      .core_clk_in(core_clk_in),
      .rst_in(rst_in),
      .reg_addr_in(reg_addr_in),
      .reg_wdata_in(reg_wdata_in),
      .reg_wr_in(reg_wr_in),
      .reg_rd_in(reg_rd_in),
      .reg_rdata_out(rdata),
      .ext_count_input_in(pin),
      .watchdog_tick_in(tick),
      .watchdog_clear_op_in(clr),
      .watchdog_tick_out(wd_out),
      .overflow_flag_out(ovf),
      .timer_count_out(tcount),
      .porta_direction_out(porta)
   );
   tmps_pulse_src u_src (
      .core_clk_in(core_clk_in),
      .count_pin_out(pin)
   );
   // ==========================================================
   // Bus, compare and watchdog pulse helpers
   task check(input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         failures++;
         $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk_in);
      reg_wr_in <= 1'b1;
      reg_addr_in <= a;
      reg_wdata_in <= d;
      @(posedge core_clk_in);
      reg_wr_in <= 1'b0;
   endtask
   task rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge core_clk_in);
      reg_rd_in <= 1'b1;
      reg_addr_in <= a;
      @(posedge core_clk_in);
      reg_rd_in <= 1'b0;
      #1 check(rdata, exp);
   endtask
   task pulse(input logic [1:0] k);
      @(posedge core_clk_in);
      {clr, tick} <= k;
      @(posedge core_clk_in);
      {clr, tick} <= 2'b00;
      repeat (3) @(posedge core_clk_in);
   endtask
   // ==========================================================
   // Scenarios
   task t_regs;
      rd(8'h81, 8'hFF);
      rd(8'h01, 8'h00);
      rd(8'h85, 8'h3F);
      rd(8'h02, 8'h00);
      wr(8'h85, 8'hFF);
      rd(8'h85, 8'h3F);
      check(porta, 8'h3F);
   endtask
   // Six Q4 ends follow the write; the first two are swallowed
   task t_internal;
      wr(8'h81, 8'h08);
      wr(8'h01, 8'hFE);
      repeat (23) @(posedge core_clk_in);
      rd(8'h01, 8'h02);
      check(tcount, 8'h02);
      check({7'h00, ovf}, 8'h01);
      rd(8'h0B, 8'h04);
      rd(8'h8B, 8'h04);
      wr(8'h0B, 8'h00);
      rd(8'h0B, 8'h00);
      check({7'h00, ovf}, 8'h00);
   endtask
   task t_ext(input logic [7:0] opt, input int n, input logic [7:0] exp);
      wr(8'h81, opt);
      wr(8'h01, 8'h00);
      repeat (8) @(posedge core_clk_in);
      u_src.toggle(n);
      repeat (12) @(posedge core_clk_in);
      rd(8'h01, exp);
      check(tcount, exp);
   endtask
   task t_wd;
      wr(8'h01, 8'h00);
      pulse(2'b10);
      wr(8'h81, 8'h09);
      n0 = wd_outs;
      pulse(2'b01);
      wr(8'h01, 8'h00);
      pulse(2'b01);
      pulse(2'b10);
      pulse(2'b01);
      pulse(2'b01);
      repeat (4) @(posedge core_clk_in);
      check(8'(wd_outs - n0), 8'h02);
      pulse(2'b10);
      wr(8'h81, 8'h00);
      n0 = wd_outs;
      pulse(2'b01);
      pulse(2'b10);
      pulse(2'b01);
      pulse(2'b01);
      repeat (4) @(posedge core_clk_in);
      check(8'(wd_outs - n0), 8'h03);
      // Internal source at 1:2: the write window drops the first scaled edge
      wr(8'h01, 8'h00);
      repeat (22) @(posedge core_clk_in);
      rd(8'h01, 8'h02);
   endtask
   task report_and_stop;
      $display("Checks %0d, mismatches %0d", check_count, failures);
      if (failures == 0 && check_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   initial
   begin
      #300000;
      failures++;
      $display("ERROR %0t: run hung", $time);
      report_and_stop;
   end
   initial
   begin
      repeat (2) @(posedge core_clk_in);
      rst_in <= 1'b0;
      t_regs;
      t_internal;
      t_ext(8'h28, 7, 8'h04);
      t_ext(8'h38, 7, 8'h04);
      for (int r = 0; r < 8; r++)
         t_ext(8'h20 + 8'(r), 8 << r, 8'h02);
      t_wd;
      report_and_stop;
   end
endmodule
bind tmps_top tmps_checker u_chk (
   .core_clk_in(core_clk_in),
   .rst_in(rst_in),
   .reg_addr_in(reg_addr_in),
   .reg_wdata_in(reg_wdata_in),
   .reg_wr_in(reg_wr_in),
   .reg_rd_in(reg_rd_in),
   .reg_rdata_out(reg_rdata_out),
   .ext_count_input_in(ext_count_input_in),
   .watchdog_tick_in(watchdog_tick_in),
   .watchdog_clear_op_in(watchdog_clear_op_in),
   .watchdog_tick_out(watchdog_tick_out),
   .overflow_flag_out(overflow_flag_out),
   .timer_count_out(timer_count_out),
   .porta_direction_out(porta_direction_out)
);
